// ---- core/pmsc_ctrl.sv ----
// Power mode sequencer and system clock selection control.
// Assumes core acknowledges halt; wake inputs are asynchronous pins.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pmsc_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdData,
  input  wire logic       irqPending,
  input  wire logic       tmr4Evt,
  input  wire logic       portMatchEvt,
  input  wire logic       cmp0Level,
  input  wire logic       cluIrqEvt,
  output logic            coreClkEn,
  output logic [7:0]      periClkEn,
  output logic            hfOscEn,
  output logic            fsOscEn,
  output logic            regLowBias,
  output logic            pinHold,
  output logic            corePowerOff,
  output logic            tmr3LfClk,
  output logic            tmr4LfClk,
  output logic [2:0]      clkSrcSel,
  output logic [2:0]      clkDivSel
);
  typedef struct packed {
    pmsc_pkg::pmsc_mode_t mode;
    logic                 shutSel;
    logic [1:0]           lfTmr;
    logic [2:0]           src;
    logic [2:0]           div;
    logic [7:0]           periEn;
    logic                 cmp0Prev;
    logic [7:0]           rdData;
    logic                 coreClkEn;
    logic [7:0]           periClkEn;
    logic                 hfOscEn;
    logic                 fsOscEn;
    logic                 regLowBias;
    logic                 pinHold;
    logic                 corePowerOff;
    logic                 tmr3LfClk;
    logic                 tmr4LfClk;
  } pmsc_state_t;
  pmsc_state_t st_r;
  pmsc_state_t st_nxt;
  logic [3:0] wakeSync;
  logic       snoozeWake;
  logic       wrPwr0;
  logic       wrPwr1;
  pmsc_sync3 #(
    .W (4)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({tmr4Evt, portMatchEvt, cmp0Level, cluIrqEvt}),
    .dout  (wakeSync)
  );
  assign snoozeWake = wakeSync[3] | wakeSync[2] | wakeSync[0]
                    | (st_r.cmp0Prev & ~wakeSync[1]);
  assign wrPwr0 = wrStb && (addr == pmsc_pkg::ADDR_PWR0);
  assign wrPwr1 = wrStb && (addr == pmsc_pkg::ADDR_PWR1);
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cmp0Prev = wakeSync[1];
    st_nxt.rdData   = 8'h00;
    if (wrStb) begin
      unique case (addr)
        pmsc_pkg::ADDR_REG0: begin
          st_nxt.shutSel = wrData[pmsc_pkg::BIT_SHUTSEL];
          st_nxt.lfTmr   = wrData[pmsc_pkg::BIT_LFTMR4:pmsc_pkg::BIT_LFTMR3];
        end
        pmsc_pkg::ADDR_CLKSEL: begin
          st_nxt.src = wrData[2:0];
          st_nxt.div = wrData[6:4];
        end
        pmsc_pkg::ADDR_PERIEN: begin
          st_nxt.periEn = wrData;
        end
        default: begin
        end
      endcase
    end
    unique case (st_r.mode)
      pmsc_pkg::PM_NORMAL: begin
        if (wrPwr0 && wrData[pmsc_pkg::BIT_IDLE]) begin
          st_nxt.mode = pmsc_pkg::PM_IDLE;
        end
        if (wrPwr0 && wrData[pmsc_pkg::BIT_STOP]) begin
          st_nxt.mode = st_r.shutSel ? pmsc_pkg::PM_SHUTDOWN
                                     : pmsc_pkg::PM_STOP;
        end
        if (wrPwr1 && wrData[pmsc_pkg::BIT_SNOOZE]) begin
          st_nxt.mode = pmsc_pkg::PM_SNOOZE;
        end
      end
      pmsc_pkg::PM_IDLE: begin
        if (irqPending) begin
          st_nxt.mode = pmsc_pkg::PM_NORMAL;
        end
      end
      pmsc_pkg::PM_SNOOZE: begin
        if (snoozeWake) begin
          st_nxt.mode = pmsc_pkg::PM_NORMAL;
        end
      end
      pmsc_pkg::PM_STOP, pmsc_pkg::PM_SHUTDOWN: begin
      end
      default: begin
        st_nxt.mode = pmsc_pkg::PM_NORMAL;
      end
    endcase
    if (rdStb) begin
      unique case (addr)
        // Idle and snooze request bits read back as mode; stop bit reads 0
        pmsc_pkg::ADDR_PWR0: begin
          st_nxt.rdData[pmsc_pkg::BIT_IDLE] = (st_r.mode == pmsc_pkg::PM_IDLE);
        end
        pmsc_pkg::ADDR_PWR1: begin
          st_nxt.rdData[pmsc_pkg::BIT_SNOOZE] =
            (st_r.mode == pmsc_pkg::PM_SNOOZE);
        end
        pmsc_pkg::ADDR_REG0: begin
          st_nxt.rdData = {5'h00, st_r.lfTmr, st_r.shutSel};
        end
        pmsc_pkg::ADDR_CLKSEL: begin
          st_nxt.rdData = {1'b0, st_r.div, 1'b0, st_r.src};
        end
        pmsc_pkg::ADDR_PERIEN: begin
          st_nxt.rdData = st_r.periEn;
        end
        pmsc_pkg::ADDR_STATUS: begin
          st_nxt.rdData = {4'h0, wakeSync};
        end
        default: begin
        end
      endcase
    end
    st_nxt.coreClkEn = (st_nxt.mode == pmsc_pkg::PM_NORMAL);
    st_nxt.periClkEn = (st_nxt.mode == pmsc_pkg::PM_NORMAL
                     || st_nxt.mode == pmsc_pkg::PM_IDLE)
                     ? st_nxt.periEn : 8'h00;
    st_nxt.hfOscEn      = (st_nxt.mode == pmsc_pkg::PM_NORMAL
                        || st_nxt.mode == pmsc_pkg::PM_IDLE);
    st_nxt.fsOscEn      = st_nxt.hfOscEn;
    st_nxt.regLowBias   = (st_nxt.mode == pmsc_pkg::PM_SNOOZE);
    st_nxt.pinHold      = (st_nxt.mode == pmsc_pkg::PM_STOP
                        || st_nxt.mode == pmsc_pkg::PM_SHUTDOWN);
    st_nxt.corePowerOff = (st_nxt.mode == pmsc_pkg::PM_SHUTDOWN);
    st_nxt.tmr3LfClk = st_nxt.lfTmr[0];
    st_nxt.tmr4LfClk = st_nxt.lfTmr[1];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r              <= '0;
      st_r.mode         <= pmsc_pkg::PM_NORMAL;
      st_r.src          <= pmsc_pkg::RST_SRC;
      st_r.div          <= pmsc_pkg::RST_DIV;
      st_r.periEn       <= pmsc_pkg::RST_PERIEN;
      st_r.coreClkEn    <= 1'b1;
      st_r.hfOscEn      <= 1'b1;
      st_r.fsOscEn      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign rdData       = st_r.rdData;
  assign coreClkEn    = st_r.coreClkEn;
  assign periClkEn    = st_r.periClkEn;
  assign hfOscEn      = st_r.hfOscEn;
  assign fsOscEn      = st_r.fsOscEn;
  assign regLowBias   = st_r.regLowBias;
  assign pinHold      = st_r.pinHold;
  assign corePowerOff = st_r.corePowerOff;
  assign tmr3LfClk    = st_r.tmr3LfClk;
  assign tmr4LfClk    = st_r.tmr4LfClk;
  // Code 5 is the 24.5 MHz / 1.5 source
  assign clkSrcSel    = st_r.src;
  assign clkDivSel    = st_r.div;
endmodule
`default_nettype wire

// ---- core/pmsc_sync3.sv ----
// Three-stage synchroniser with agreement filter.
// Assumes async inputs; output changes when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pmsc_sync3 #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pmsc_sync_t;
  pmsc_sync_t st_r;
  pmsc_sync_t st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.q;
endmodule
`default_nettype wire

// ---- include/pmsc_pkg.sv ----
// Package for the power mode and system clock controller.
// Assumes one 100 MHz clock and a plain strobe register port.
// Notes on behaviour
// - In normal mode the core and the peripherals enabled in periEn stay clocked.
// - Setting the idle bit halts the core only; any interrupt ends idle.
// - Leaving idle or snooze resumes the program, with no reset.
// - Stop halts the high-frequency oscillator, holds pins, ends by reset.
// - Snooze halts core and peripheral clocks, both fast oscillators, and lowers bias.
// - In snooze the third and fourth timers may run from the low-frequency oscillator.
// - Snooze wakes on fourth-timer, port match, comparator 0 fall or logic unit event.
// - Shutdown removes internal power, holds pins, ends by pin or power-on reset.
// - Clocks of unused digital peripherals are gated off.
// - After reset the system clock is the 24.5 MHz output divided by eight.
// - The divider offers eight power-of-two settings from 1 to 128.
// - The source selector offers the 49 MHz, 10 MHz, 80 kHz, external and derived clocks.
// - A 24.5 MHz divided by 1.5 source is among the selectable sources.
package pmsc_pkg;
  localparam logic [3:0] ADDR_PWR0   = 4'h0;
  localparam logic [3:0] ADDR_PWR1   = 4'h1;
  localparam logic [3:0] ADDR_REG0   = 4'h2;
  localparam logic [3:0] ADDR_CLKSEL = 4'h3;
  localparam logic [3:0] ADDR_PERIEN = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam int BIT_IDLE     = 0;
  localparam int BIT_STOP     = 1;
  localparam int BIT_SNOOZE   = 0;
  localparam int BIT_SHUTSEL  = 0;
  localparam int BIT_LFTMR3   = 1;
  localparam int BIT_LFTMR4   = 2;
  localparam int NUM_PERI     = 8;
  // Clock source codes
  localparam logic [2:0] SRC_HF24     = 3'h0;
  localparam logic [2:0] SRC_HF49     = 3'h1;
  localparam logic [2:0] SRC_FS10     = 3'h2;
  localparam logic [2:0] SRC_LF80     = 3'h3;
  localparam logic [2:0] SRC_EXT      = 3'h4;
  localparam logic [2:0] SRC_HF24_D15 = 3'h5;
  localparam logic [2:0] SRC_FS_D4    = 3'h6;
  localparam logic [2:0] SRC_HF49_D15 = 3'h7;
  localparam logic [2:0] RST_SRC      = SRC_HF24;
  localparam logic [2:0] RST_DIV      = 3'h3;
  localparam logic [7:0] RST_PERIEN   = 8'h00;
  typedef enum logic [2:0] {
    PM_NORMAL   = 3'b000,
    PM_IDLE     = 3'b001,
    PM_SNOOZE   = 3'b011,
    PM_STOP     = 3'b010,
    PM_SHUTDOWN = 3'b110
  } pmsc_mode_t;
endpackage

// ---- tb/pmsc_core_model.sv ----
// Core interrupt line and snooze wake sources.
// Assumes wakeGo is a one-cycle pulse with wakeSel set.
`timescale 1ns/1ps
`default_nettype none
module pmsc_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       coreClkEn,
  input  wire logic [2:0] wakeSel,
  input  wire logic       wakeGo,
  output logic            irqPending,
  output logic            tmr4Evt,
  output logic            portMatchEvt,
  output logic            cmp0Level,
  output logic            cluIrqEvt
);
  logic [4:0] act;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      act <= 5'h00;
    else if (wakeGo)
      act <= 5'h01 << wakeSel;
    else if (coreClkEn)
      act <= 5'h00;
  end
  assign irqPending   = act[0];
  assign tmr4Evt      = act[1];
  assign portMatchEvt = act[2];
  assign cmp0Level    = !act[3];
  assign cluIrqEvt    = act[4];
endmodule
`default_nettype wire

// ---- tb/pmsc_ctrl_sva.sv ----
// Port checker for pmsc_ctrl.
// Assumes one clock; bound to every pmsc_ctrl.
`timescale 1ns/1ps
`default_nettype none
module pmsc_ctrl_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  input wire logic       irqPending,
  input wire logic       tmr4Evt,
  input wire logic       portMatchEvt,
  input wire logic       cmp0Level,
  input wire logic       cluIrqEvt,
  input wire logic       coreClkEn,
  input wire logic [7:0] periClkEn,
  input wire logic       hfOscEn,
  input wire logic       fsOscEn,
  input wire logic       regLowBias,
  input wire logic       pinHold,
  input wire logic       corePowerOff,
  input wire logic [2:0] clkSrcSel,
  input wire logic [2:0] clkDivSel
);
  logic selW1;
  logic selW2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selW1 <= 1'h0;
      selW2 <= 1'h0;
    end else begin
      selW1 <= wrStb && addr == pmsc_pkg::ADDR_CLKSEL;
      selW2 <= selW1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_normal_run:
    assert property (coreClkEn |-> hfOscEn && !pinHold && !regLowBias)
    else $error("normal mode not fully running");
  chk_idle_enter:
    assert property (wrStb && addr == pmsc_pkg::ADDR_PWR0 && coreClkEn
      && wrData[1:0] == 2'h1 |-> ##[1:2] !coreClkEn && hfOscEn)
    else $error("idle not entered");
  chk_idle_wake:
    assert property (!coreClkEn && hfOscEn && irqPending |-> ##[1:2] coreClkEn)
    else $error("idle not left on interrupt");
  chk_hold_stays:
    assert property (pinHold |=> pinHold && !coreClkEn)
    else $error("stop left without reset");
  chk_snooze_off:
    assert property (regLowBias |-> !coreClkEn && !hfOscEn && !fsOscEn
      && periClkEn == 8'h00)
    else $error("snooze clocks not halted");
  chk_snooze_wake:
    assert property (regLowBias && (tmr4Evt || portMatchEvt || cluIrqEvt
      || !cmp0Level) |-> ##[1:8] !regLowBias)
    else $error("snooze wake missed");
  chk_shut_power:
    assert property (corePowerOff |-> pinHold && !hfOscEn && !coreClkEn)
    else $error("shutdown state wrong");
  chk_reset_clk:
    assert property ($rose(rst_n) |-> clkSrcSel == pmsc_pkg::SRC_HF24
      && clkDivSel == pmsc_pkg::RST_DIV)
    else $error("reset clock wrong");
  chk_clk_change:
    assert property ($changed(clkSrcSel) || $changed(clkDivSel)
      |-> selW1 || selW2)
    else $error("clock select changed unasked");
  chk_read_quiet:
    assert property (!rdStb |=> rdData == 8'h00)
    else $error("read data outside its cycle");
endmodule
bind pmsc_ctrl pmsc_ctrl_sva pmsc_ctrl_sva_inst (.*);
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for pmsc_ctrl with the core model.
// Assumes 100 MHz clock, fixed stimulus.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, wrStb = 0, rdStb = 0, wakeGo = 0;
  logic [3:0] addr = 0;
  logic [7:0] wrData = 0, rdData, periClkEn;
  logic [2:0] wakeSel = 0, clkSrcSel, clkDivSel;
  logic irqPending, tmr4Evt, portMatchEvt, cmp0Level, cluIrqEvt;
  logic coreClkEn, hfOscEn, fsOscEn, regLowBias, pinHold, corePowerOff;
  logic tmr3LfClk, tmr4LfClk;
  int n_errors = 0, total_checks = 0;
  logic [5:0] rows [8] = '{6'o07, 6'o16, 6'o25, 6'o34, 6'o43, 6'o52,
                           6'o61, 6'o70};
  pmsc_ctrl pmsc_ctrl_inst (.*);
  pmsc_core_model pmsc_core_model_inst (.*);
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wrStb  <= 1'h1;
    addr   <= a;
    wrData <= d;
    @(posedge clk);
    wrStb <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rdStb <= 1'h1;
    addr  <= a;
    @(posedge clk);
    rdStb <= 1'h0;
    #1;
    chk(rdData, e);
  endtask
  task automatic wake(input logic [2:0] s);
    @(posedge clk);
    wakeSel <= s;
    wakeGo  <= 1'h1;
    @(posedge clk);
    wakeGo <= 1'h0;
    for (int i = 0; i < 12 && coreClkEn !== 1'h1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic doReset;
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk({5'h0, clkSrcSel}, {5'h0, pmsc_pkg::SRC_HF24});
    chk({5'h0, clkDivSel}, 8'h03);
    chk({coreClkEn, hfOscEn, regLowBias, pinHold, 4'h0}, 8'hC0);
    chk(periClkEn, 8'h00);
  endtask
  task automatic test_done;
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    test_done();
  end
  initial begin
    doReset();
    foreach (rows[i]) begin
      wr(pmsc_pkg::ADDR_CLKSEL, {1'h0, rows[i][2:0], 1'h0, rows[i][5:3]});
      chk({2'h0, clkSrcSel, clkDivSel}, {2'h0, rows[i]});
      rdc(pmsc_pkg::ADDR_CLKSEL, {1'h0, rows[i][2:0], 1'h0, rows[i][5:3]});
    end
    rdc(4'hF, 8'h00);
    rdc(pmsc_pkg::ADDR_STATUS, 8'h02);
    wr(pmsc_pkg::ADDR_REG0, 8'h06);
    wr(pmsc_pkg::ADDR_PERIEN, 8'h5A);
    chk(periClkEn, 8'h5A);
    wr(pmsc_pkg::ADDR_PWR0, 8'h01);
    chk({coreClkEn, hfOscEn, 6'h0}, 8'h40);
    chk(periClkEn, 8'h5A);
    wr(pmsc_pkg::ADDR_PWR1, 8'h01);
    chk({coreClkEn, hfOscEn, regLowBias, 5'h0}, 8'h40);
    wake(3'h0);
    rdc(pmsc_pkg::ADDR_PWR0, 8'h00);
    rdc(pmsc_pkg::ADDR_CLKSEL, 8'h07);
    wr(pmsc_pkg::ADDR_CLKSEL, 8'h00);
    for (int s = 1; s < 5; s++) begin
      wr(pmsc_pkg::ADDR_PWR1, 8'h01);
      chk({coreClkEn, hfOscEn, fsOscEn, regLowBias, 4'h0}, 8'h10);
      chk({6'h0, tmr4LfClk, tmr3LfClk}, 8'h03);
      wake(s[2:0]);
      chk(periClkEn, 8'h5A);
      rdc(pmsc_pkg::ADDR_PWR1, 8'h00);
    end
    wr(pmsc_pkg::ADDR_PWR0, 8'h02);
    chk({hfOscEn, pinHold, corePowerOff, 5'h0}, 8'h40);
    wake(3'h0);
    chk({coreClkEn, pinHold, 6'h0}, 8'h40);
    doReset();
    wr(pmsc_pkg::ADDR_REG0, 8'h01);
    wr(pmsc_pkg::ADDR_PWR0, 8'h02);
    chk({hfOscEn, pinHold, corePowerOff, 5'h0}, 8'h60);
    doReset();
    test_done();
  end
endmodule
`default_nettype wire
